/* File: pcs_cfg_rom.sv */
`timescale 1ns/1ps
module pcs_cfg_rom (
  input wire logic clk, // clock
  input wire logic rst, // sync reset
  input wire logic [7:0] addr, // byte offset
  input wire logic [15:0] status_word, // live status word
  output logic [15:0] rdata // registered read data
);
  logic [15:0] rdata_nxt;

  // byte-offset decode of readable words
  always_comb begin
    rdata_nxt = 16'h0000;
    if (addr == pcs_pkg::STATUS_OFS) begin
      rdata_nxt = status_word;
    end else if (addr == pcs_pkg::REVISION_OFS) begin
      rdata_nxt = {8'h00, pcs_pkg::REVISION_DEFAULT};
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rdata <= 16'h0000;
    end else begin
      rdata <= rdata_nxt;
    end
  end
endmodule : pcs_cfg_rom

/* File: pcs_host.sv */
`timescale 1ns/1ps
module pcs_host (
  input wire logic clk, // clock
  input wire logic [15:0] cfg_rdata, // answer
  output logic cfg_rd = 1'h0, // read strobe
  output logic cfg_wr = 1'h0, // write strobe
  output logic [7:0] cfg_addr = 8'h00, // offset
  output logic [15:0] cfg_wdata = 16'h0000 // write data
);
  // one config cycle, answer taken at the next falling edge, offset then scrambled
  task automatic xfer(input logic w, input logic [7:0] a, output logic [15:0] d);
    @(negedge clk);
    {cfg_rd, cfg_wr, cfg_addr, cfg_wdata} = {~w, w, a, ~cfg_rdata};
    @(negedge clk);
    d = cfg_rdata;
    {cfg_rd, cfg_wr, cfg_addr} = {2'h0, ~a};
  endtask : xfer
endmodule : pcs_host

/* File: pcs_pkg.sv */
package pcs_pkg;
  // configuration offsets
  localparam logic [7:0] STATUS_OFS = 8'h06;
  localparam logic [7:0] REVISION_OFS = 8'h08;
  localparam logic [7:0] CAPS_PTR_OFS = 8'h34;
  // status field positions and command parity response bit
  localparam int SPEED_LO = 9;
  localparam int SPEED_HI = 10;
  localparam int PARITY_FAULT_BIT = 8;
  localparam int BACK_TO_BACK_BIT = 7;
  localparam int DOUBLE_SPEED_BIT = 5;
  localparam int CAPS_BIT = 4;
  localparam int PARITY_RESP_CMD_BIT = 6;
  // select response speed codes
  localparam logic [1:0] SPEED_FAST = 2'h0;
  localparam logic [1:0] SPEED_MEDIUM = 2'h1;
  localparam logic [1:0] SPEED_SLOW = 2'h2;
  // reset values; revision value is arbitrary
  localparam logic [1:0] SPEED_DEFAULT = SPEED_MEDIUM;
  localparam logic BACK_TO_BACK_DEFAULT = 1'h0;
  localparam logic DOUBLE_SPEED_DEFAULT = 1'h0;
  localparam logic CAPS_DEFAULT = 1'h1;
  localparam logic [7:0] REVISION_DEFAULT = 8'h5a;
  localparam logic [15:0] STATUS_RESET = 16'h0000;
  localparam logic [7:0] READ_DEFAULT = 8'h00;
endpackage : pcs_pkg

/* File: pcs_status.sv */
`timescale 1ns/1ps
// Operation
// - select speed field at bits 10:9, never 11b
// - speed field reports slowest non-config response
// - parity flag: own read perr or seen write perr
// - parity flag also needs master and response enable
// - bit 7 read-only back-to-back capability
// - bit 5 read-only 66 MHz capability
// - bit 4 flags capability list at 34h; offset 34h itself reads 0000h
// - read-only revision byte at offset 08h
// - status word read-only, writes ignored
module pcs_status (
  input wire logic clk, // clock
  input wire logic rst, // sync reset
  input wire logic [1:0] slowest_speed, // slowest non-config decode speed
  input wire logic back_to_back_accept_cap, // fast back-to-back strap
  input wire logic double_speed_cap, // 66 MHz strap
  input wire logic extended_caps_present, // capability list strap
  input wire logic [15:0] command_word, // command register value
  input wire logic bus_master_active, // device is master of transfer
  input wire logic read_perr_driven, // device drove perr on its read
  input wire logic write_perr_seen, // perr seen on device write
  input wire logic cfg_rd, // config read strobe
  input wire logic cfg_wr, // config write strobe, ignored
  input wire logic [7:0] cfg_addr, // config byte offset
  input wire logic [15:0] cfg_wdata, // config write data, ignored
  output logic [15:0] cfg_rdata, // registered read data
  output logic cfg_rd_valid, // read data valid pulse
  output logic master_parity_fault_flag, // status bit 8
  output logic [1:0] select_response_speed // status bits 10:9
);
  // parity fault flag state
  logic parity_fault_r;
  logic parity_fault_nxt;

  // select response speed state
  logic [1:0] speed_r;
  logic [1:0] speed_nxt;

  // back-to-back capability state
  logic b2b_r;
  logic b2b_nxt;

  // double speed capability state
  logic dbl_r;
  logic dbl_nxt;

  // capability list state
  logic caps_r;
  logic caps_nxt;

  // read answer state
  logic valid_r;
  logic valid_nxt;

  // combinational helpers
  logic parity_resp_en;
  logic fault_cause;
  logic [15:0] status_word;
  logic [15:0] rom_rdata;
  logic unused_ok;

  // reserved decode speed is reported as slow
  function automatic logic [1:0] legal_speed(input logic [1:0] raw);
    logic [1:0] code;
    code = raw;
    if (raw == 2'h3) begin
      code = pcs_pkg::SPEED_SLOW;
    end
    return code;
  endfunction : legal_speed

  // parity error on a mastered transfer with response enabled
  function automatic logic fault_event(
    input logic master, // device was master
    input logic enable, // parity response enable
    input logic read_err, // own perr on a read
    input logic write_err // perr seen on a write
  );
    return master && enable && (read_err || write_err);
  endfunction : fault_event

  // places the fields at their status bit positions
  function automatic logic [15:0] pack_status(
    input logic [1:0] speed, // select response speed
    input logic fault, // master parity fault
    input logic b2b, // back-to-back capability
    input logic dbl, // double speed capability
    input logic caps // capability list present
  );
    logic [15:0] word;
    word = pcs_pkg::STATUS_RESET;
    word[pcs_pkg::SPEED_HI:pcs_pkg::SPEED_LO] = speed;
    word[pcs_pkg::PARITY_FAULT_BIT] = fault;
    word[pcs_pkg::BACK_TO_BACK_BIT] = b2b;
    word[pcs_pkg::DOUBLE_SPEED_BIT] = dbl;
    word[pcs_pkg::CAPS_BIT] = caps;
    return word;
  endfunction : pack_status

  // parity response enable from command bit 6
  assign parity_resp_en = command_word[pcs_pkg::PARITY_RESP_CMD_BIT];

  // parity fault cause in this cycle
  assign fault_cause = fault_event(bus_master_active, parity_resp_en,
    read_perr_driven, write_perr_seen);

  // host writes never reach the status state
  assign unused_ok = cfg_wr ^ (^cfg_wdata);

  // flag sets on a cause and holds until reset, no clear path
  always_comb begin
    parity_fault_nxt = parity_fault_r;
    if (fault_cause) begin
      parity_fault_nxt = 1'b1;
    end
  end

  // register the parity fault flag
  always_ff @(posedge clk) begin
    if (rst) begin
      parity_fault_r <= 1'b0;
    end else begin
      parity_fault_r <= parity_fault_nxt;
    end
  end

  // speed follows the slowest decode speed
  always_comb begin
    speed_nxt = legal_speed(slowest_speed);
  end

  // register the select response speed
  always_ff @(posedge clk) begin
    if (rst) begin
      speed_r <= pcs_pkg::SPEED_DEFAULT;
    end else begin
      speed_r <= speed_nxt;
    end
  end

  // back-to-back capability follows its strap
  always_comb begin
    b2b_nxt = back_to_back_accept_cap;
  end

  // register the back-to-back capability
  always_ff @(posedge clk) begin
    if (rst) begin
      b2b_r <= pcs_pkg::BACK_TO_BACK_DEFAULT;
    end else begin
      b2b_r <= b2b_nxt;
    end
  end

  // double speed capability follows its strap
  always_comb begin
    dbl_nxt = double_speed_cap;
  end

  // register the double speed capability
  always_ff @(posedge clk) begin
    if (rst) begin
      dbl_r <= pcs_pkg::DOUBLE_SPEED_DEFAULT;
    end else begin
      dbl_r <= dbl_nxt;
    end
  end

  // capability list flag follows its strap
  always_comb begin
    caps_nxt = extended_caps_present;
  end

  // register the capability list flag
  always_ff @(posedge clk) begin
    if (rst) begin
      caps_r <= pcs_pkg::CAPS_DEFAULT;
    end else begin
      caps_r <= caps_nxt;
    end
  end

  // one-cycle answer pulse for each read strobe
  always_comb begin
    valid_nxt = 1'b0;
    if (cfg_rd) begin
      valid_nxt = 1'b1;
    end
  end

  // register the answer pulse
  always_ff @(posedge clk) begin
    if (rst) begin
      valid_r <= 1'b0;
    end else begin
      valid_r <= valid_nxt;
    end
  end

  // status word from the registered fields
  always_comb begin
    status_word = pack_status(speed_r, parity_fault_r, b2b_r,
      dbl_r, caps_r);
  end

  // read mux
  pcs_cfg_rom u_rom (
    .clk(clk),
    .rst(rst),
    .addr(cfg_addr),
    .status_word(status_word),
    .rdata(rom_rdata)
  );

  assign cfg_rdata = rom_rdata;
  assign cfg_rd_valid = valid_r;
  assign master_parity_fault_flag = parity_fault_r;
  assign select_response_speed = speed_r;
endmodule : pcs_status

/* File: pcs_status_assertions.sv */
`timescale 1ns/1ps
module pcs_chk (
  input wire logic clk, // clock
  input wire logic rst, // sync reset
  input wire logic cfg_rd, // read strobe
  input wire logic cfg_rd_valid, // read answer pulse
  input wire logic bus_master_active, // device is master
  input wire logic read_perr_driven, // own perr on a read
  input wire logic write_perr_seen, // perr seen on a write
  input wire logic master_parity_fault_flag, // flag
  input wire logic [1:0] select_response_speed, // speed
  input wire logic [7:0] cfg_addr, // offset
  input wire logic [15:0] command_word, // command
  input wire logic [15:0] cfg_rdata // read data
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // flag alias and its cause
  wire f = master_parity_fault_flag;
  wire c = bus_master_active && command_word[pcs_pkg::PARITY_RESP_CMD_BIT]
    && (read_perr_driven || write_perr_seen);
  property p_v; cfg_rd |=> cfg_rd_valid; endproperty
  a_v: assert property (p_v) else $error("no answer");
  property p_o; !cfg_rd |=> !cfg_rd_valid; endproperty
  a_o: assert property (p_o) else $error("extra answer");
  property p_s; select_response_speed != 2'h3; endproperty
  a_s: assert property (p_s) else $error("bad speed");
  property p_set; c |=> f; endproperty
  a_set: assert property (p_set) else $error("flag missed");
  property p_clr; !c && !f |=> !f; endproperty
  a_clr: assert property (p_clr) else $error("false flag");
  property p_k; f |=> f; endproperty
  a_k: assert property (p_k) else $error("flag lost");
  property p_z; $past(cfg_addr) == 8'h06 |-> (cfg_rdata & 16'h004f) == 16'h0000; endproperty
  a_z: assert property (p_z) else $error("reserved set");
  property p_r;
    cfg_rd_valid && $past(cfg_addr) == pcs_pkg::REVISION_OFS
      |-> cfg_rdata == {8'h00, pcs_pkg::REVISION_DEFAULT};
  endproperty
  a_r: assert property (p_r) else $error("bad revision");
  // main scenarios
  cover property (cfg_rd_valid);
  cover property ($rose(f));
  cover property (select_response_speed == 2'h2);
endmodule : pcs_chk
bind pcs_status pcs_chk u_chk (
  .clk(clk),
  .rst(rst),
  .cfg_rd(cfg_rd),
  .cfg_rd_valid(cfg_rd_valid),
  .bus_master_active(bus_master_active),
  .read_perr_driven(read_perr_driven),
  .write_perr_seen(write_perr_seen),
  .master_parity_fault_flag(master_parity_fault_flag),
  .select_response_speed(select_response_speed),
  .cfg_addr(cfg_addr),
  .command_word(command_word),
  .cfg_rdata(cfg_rdata)
);

/* File: pcs_status_tb.sv */
`timescale 1ns/1ps
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin error_cnt++; \
  $display("ERROR t=%0t got %h exp %h", $time, a, e); end end
module pcs_status_tb;
  logic clk = 1'h0, rst = 1'h1, bus_master_active = 1'h0, read_perr_driven = 1'h0;
  logic write_perr_seen = 1'h0, back_to_back_accept_cap = 1'h0, double_speed_cap = 1'h0;
  logic extended_caps_present = 1'h0, cfg_rd, cfg_wr, cfg_rd_valid, master_parity_fault_flag;
  logic [1:0] slowest_speed = 2'h0, select_response_speed;
  logic [7:0] cfg_addr;
  logic [15:0] command_word = 16'h0000, cfg_wdata, cfg_rdata, d;
  int error_cnt = 0, samples_checked = 0, cyc = 0;
  // speed, straps, offset, expected read
  localparam logic [28:0] ROWS [6] = '{{2'h0, 3'h1, 8'h06, 16'h0010},
    {2'h1, 3'h4, 8'h06, 16'h0280}, {2'h2, 3'h3, 8'h06, 16'h0430}, {2'h3, 3'h7, 8'h06, 16'h04b0},
    {2'h1, 3'h0, 8'h08, 8'h00, pcs_pkg::REVISION_DEFAULT}, {2'h1, 3'h0, 8'h34, 16'h0000}};
  pcs_status dut (
    .clk(clk),
    .rst(rst),
    .slowest_speed(slowest_speed),
    .back_to_back_accept_cap(back_to_back_accept_cap),
    .double_speed_cap(double_speed_cap),
    .extended_caps_present(extended_caps_present),
    .command_word(command_word),
    .bus_master_active(bus_master_active),
    .read_perr_driven(read_perr_driven),
    .write_perr_seen(write_perr_seen),
    .cfg_rd(cfg_rd),
    .cfg_wr(cfg_wr),
    .cfg_addr(cfg_addr),
    .cfg_wdata(cfg_wdata),
    .cfg_rdata(cfg_rdata),
    .cfg_rd_valid(cfg_rd_valid),
    .master_parity_fault_flag(master_parity_fault_flag),
    .select_response_speed(select_response_speed)
  );
  pcs_host host (
    .clk(clk),
    .cfg_rdata(cfg_rdata),
    .cfg_rd(cfg_rd),
    .cfg_wr(cfg_wr),
    .cfg_addr(cfg_addr),
    .cfg_wdata(cfg_wdata)
  );
  always #10 clk = ~clk;
  // cycle ceiling
  always @(posedge clk) if (++cyc == 2000) begin error_cnt++; print_verdict(); end
  task automatic print_verdict();
    $display("checked %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : print_verdict
  // table rows, then write, parity and reset cases
  initial begin
    repeat (2) @(negedge clk);
    rst = 1'h0;
    foreach (ROWS[i]) begin
      {slowest_speed, back_to_back_accept_cap, double_speed_cap,
        extended_caps_present} = ROWS[i][28:24];
      repeat (3) @(negedge clk);
      host.xfer(1'h0, ROWS[i][23:16], d);
      `CHK(d, ROWS[i][15:0])
      `CHK(cfg_rd_valid, 1'h1)
      if (ROWS[i][23:16] == pcs_pkg::STATUS_OFS) `CHK(select_response_speed, ROWS[i][10:9])
    end
    $display("table done");
    host.xfer(1'h1, 8'h06, d);
    `CHK(cfg_rd_valid, 1'h0)
    host.xfer(1'h0, 8'h06, d);
    `CHK(d, 16'h0200)
    {bus_master_active, read_perr_driven} = 2'h3;
    @(negedge clk);
    {bus_master_active, command_word} = {1'h0, 16'h0040};
    @(negedge clk);
    `CHK(master_parity_fault_flag, 1'h0)
    {bus_master_active, read_perr_driven, write_perr_seen} = 3'h5;
    @(negedge clk);
    {bus_master_active, write_perr_seen} = 2'h0;
    host.xfer(1'h0, 8'h06, d);
    `CHK(d, 16'h0300)
    `CHK(master_parity_fault_flag, 1'h1)
    rst = 1'h1;
    repeat (2) @(negedge clk);
    `CHK({master_parity_fault_flag, select_response_speed, cfg_rd_valid}, 4'h2)
    // release reset with a read taken at the first edge after it
    fork
      host.xfer(1'h0, 8'h06, d);
      begin
        @(negedge clk);
        rst = 1'h0;
      end
    join
    `CHK(d, 16'h0210)
    host.xfer(1'h0, 8'h06, d);
    `CHK(d, 16'h0200)
    $display("hand cases done");
    print_verdict();
  end
endmodule : pcs_status_tb
